// *** shared/ssx_defines.svh ***
/*
 Offsets, field positions and reset values of the synchronous serial slave.
 Assumes a 32-bit APB slave decoding paddr[7:0], one register per word.
*/
`ifndef SSX_DEFINES_SVH
`define SSX_DEFINES_SVH
`define SSX_OFS_TX_STAT   8'h00
`define SSX_OFS_RX_STAT   8'h04
`define SSX_OFS_BAUD_CTL  8'h08
`define SSX_OFS_DIV_LO    8'h0c
`define SSX_OFS_DIV_HI    8'h10
`define SSX_OFS_TX_HOLD   8'h14
`define SSX_OFS_RX_DATA   8'h18
`define SSX_OFS_INT_CTL   8'h1c
// transmit status/control bits
`define SSX_B_CLOCK_SOURCE_MASTER  7
`define SSX_B_TX9   6
`define SSX_B_TRANSMIT_ENABLE  5
`define SSX_B_SYNC  4
`define SSX_B_TRMT  1
`define SSX_B_NINTH_BIT_TRANSMIT_VALUE  0
// receive status/control bits
`define SSX_B_SERIAL_PORT_ENABLE  7
`define SSX_B_RX9   6
`define SSX_B_SINGLE_RECEIVE_ENABLE  5
`define SSX_B_CONTINUOUS_RECEIVE_ENABLE  4
`define SSX_B_OVERRUN_ERROR  1
`define SSX_B_NINTH_BIT_RECEIVE_VALUE  0
// baud control bits
`define SSX_B_CLOCK_POLARITY_SELECT  4
`define SSX_B_WIDE_DIVISOR_SELECT 3
// interrupt control bits
`define SSX_B_GIE   7
`define SSX_B_PERIPHERAL_INT_ENABLE  6
`define SSX_B_RECEIVE_INT_ENABLE  5
`define SSX_B_TRANSMIT_INT_ENABLE  4
`define SSX_B_RECEIVE_FLAG  1
`define SSX_B_TRANSMIT_FLAG  0
`define SSX_RST_REG   8'h00
`define SSX_INT_VECTOR 16'h0004
`define SSX_BITS_8    4'h8
`define SSX_BITS_9    4'h9
`endif

// *** shared/ssx_pkg.sv ***
/*
 Types of the synchronous serial slave.
 Assumes ssx_defines.svh is included by the design file.
*/
package ssx_pkg;
  typedef struct packed {
    logic ck_out;
    logic ck_oe;
    logic dt_out;
    logic dt_oe;
  } ssx_pins_s;
  typedef struct packed {
    logic       bit9;
    logic [7:0] data;
  } ssx_char_s;
  typedef enum logic [1:0] {SSX_OFF, SSX_TX, SSX_RX, SSX_HOLD} ssx_mode_e;
endpackage

// *** logic/ssx_serial.sv ***
/*
 Synchronous serial slave engine with APB register file, two-character
 receive FIFO and sleep wake logic.
 Assumes clk_sys at 250 MHz, far faster than the external shift clock, and
 an APB master that keeps psel/penable/paddr stable through the access.
*/
// Operation
// RULE1: sync set and clock source clear selects slave mode, clock from pin.
// RULE2: both receive enables clear means transmit mode, else receive mode.
// RULE3: serial port enable gates the unit; clearing it resets the unit.
// RULE4: two words written: first goes to shifter, second held, flag clear.
// RULE5: after first shifts out, second loads, transmit flag sets, wake if enabled.
// RULE6: wake continues after sleep; global enable calls vector 0004.
// RULE7: slave receive runs on continuous enable; single enable is ignored.
// RULE8: continuous enable set lets a character arrive in sleep and wake.
// RULE9: only slave mode shifts during sleep; other modes stay still.
// RULE10: slave shifters step only on external clock pin edges.
// RULE11: software drains receive data before sleeping to receive.
// RULE12: a complete word clocked in during sleep sets receive flag.
// RULE13: software fills shifter and holding and enables interrupts first.
// RULE14: writing holding register after wake clears transmit flag.
// RULE15: master receive setup order is the software's duty.
// RULE16: receive flag sets on completed character; interrupt if enabled.
// RULE17: software reads ninth bit and status before low data byte.
// RULE18: overrun clears by clearing continuous enable or port enable.
// RULE19: slave transmit setup order is the software's duty.
// RULE20: slave receive setup order is the software's duty.
// RULE21: data changes on leading edge, sampled on trailing, one bit per clock.
// RULE22: two characters held; a third sets overrun and is refused.
// RULE23: polarity bit set means idle high, data changes on falling edges.
`include "ssx_defines.svh"
module ssx_serial #(
  parameter int FIFO_DEPTH = 2
) (
  input  wire logic              clk_sys,     // system clock
  input  wire logic              resetn,      // async reset, active low
  input  wire logic [7:0]        paddr,       // apb address
  input  wire logic              psel,        // apb select
  input  wire logic              penable,     // apb enable
  input  wire logic              pwrite,      // apb direction
  input  wire logic [31:0]       pwdata,      // apb write data
  output logic [31:0]            prdata,      // apb read data
  output logic                   pready,      // apb ready
  output logic                   pslverr,     // apb error, unmapped
  input  wire logic              ck_pin_in,   // clock pin level
  input  wire logic              dt_pin_in,   // data pin level
  output ssx_pkg::ssx_pins_s     pins_out,    // pin drives and enables
  input  wire logic              core_sleep,  // core is asleep
  output logic                   wake_req,    // wake the core
  output logic                   int_req,     // interrupt request
  output logic                   vector_call, // jump to vector on wake
  output logic [15:0]            vector_addr  // interrupt vector
);
  import ssx_pkg::*;
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  logic [7:0]  tx_stat, rx_ctl, baud_ctl, div_lo, div_hi, int_ctl, thr;
  logic        thr_full, tx_bit_out, tx_pend, overrun_error;
  logic [8:0]  transmit_shift_register, receive_shift_register;
  logic [3:0]  tx_left, rx_cnt;
  logic        ck_s1, ck_s2, ck_d, dt_s1, dt_s2;
  ssx_char_s   fifo [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [PW:0] count;
  ssx_mode_e   mode;

  // decoded controls
  logic serial_port_enable, slave, continuous_receive_enable, single_receive_enable, transmit_enable, clock_polarity_select, tx9, rx9;
  logic global_int_enable, peripheral_int_enable, receive_int_enable, transmit_int_enable, transmit_flag, receive_flag;
  assign serial_port_enable  = rx_ctl[`SSX_B_SERIAL_PORT_ENABLE];
  assign continuous_receive_enable  = rx_ctl[`SSX_B_CONTINUOUS_RECEIVE_ENABLE];
  assign single_receive_enable  = rx_ctl[`SSX_B_SINGLE_RECEIVE_ENABLE];
  assign rx9   = rx_ctl[`SSX_B_RX9];
  assign transmit_enable  = tx_stat[`SSX_B_TRANSMIT_ENABLE];
  assign tx9   = tx_stat[`SSX_B_TX9];
  assign clock_polarity_select  = baud_ctl[`SSX_B_CLOCK_POLARITY_SELECT];
  assign global_int_enable   = int_ctl[`SSX_B_GIE];
  assign peripheral_int_enable  = int_ctl[`SSX_B_PERIPHERAL_INT_ENABLE];
  assign receive_int_enable  = int_ctl[`SSX_B_RECEIVE_INT_ENABLE];
  assign transmit_int_enable  = int_ctl[`SSX_B_TRANSMIT_INT_ENABLE];
  assign slave = tx_stat[`SSX_B_SYNC] & ~tx_stat[`SSX_B_CLOCK_SOURCE_MASTER]; // [RULE1]

  // mode select; single_receive_enable only matters in choosing transmit
  always_comb begin
    if (!serial_port_enable || !slave)
      mode = SSX_OFF;                                          // [RULE3] [RULE9]
    else if (!single_receive_enable && !continuous_receive_enable)
      mode = transmit_enable ? SSX_TX : SSX_HOLD;                         // [RULE2]
    else if (continuous_receive_enable)
      mode = SSX_RX;                                           // [RULE7]
    else
      mode = SSX_HOLD;                                         // [RULE7]
  end

  // apb access strobes; zero wait states
  logic acc, wr, rd, mapped, wr_thr, pop;
  assign acc = psel & penable;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      `SSX_OFS_TX_STAT, `SSX_OFS_RX_STAT, `SSX_OFS_BAUD_CTL, `SSX_OFS_DIV_LO,
      `SSX_OFS_DIV_HI, `SSX_OFS_TX_HOLD, `SSX_OFS_RX_DATA,
      `SSX_OFS_INT_CTL: mapped = 1'b1;
      default:          mapped = 1'b0;
    endcase
  end
  assign pslverr = acc & ~mapped;
  assign wr_thr  = wr & (paddr == `SSX_OFS_TX_HOLD) & serial_port_enable;
  assign pop     = rd & (paddr == `SSX_OFS_RX_DATA) & (count != '0);

  // software-written control registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_stat  <= `SSX_RST_REG;
      rx_ctl   <= `SSX_RST_REG;
      baud_ctl <= `SSX_RST_REG;
      div_lo   <= `SSX_RST_REG;
      div_hi   <= `SSX_RST_REG;
      int_ctl  <= `SSX_RST_REG;
    end else if (wr) begin
      case (paddr)
        `SSX_OFS_TX_STAT:  tx_stat  <= pwdata[7:0] & 8'hf1;
        `SSX_OFS_RX_STAT:  rx_ctl   <= pwdata[7:0] & 8'hf0;
        `SSX_OFS_BAUD_CTL: baud_ctl <= pwdata[7:0] & 8'h18;
        `SSX_OFS_DIV_LO:   div_lo   <= pwdata[7:0];
        `SSX_OFS_DIV_HI:   div_hi   <= pwdata[7:0];
        `SSX_OFS_INT_CTL:  int_ctl  <= pwdata[7:0] & 8'hf0;
        default: ;
      endcase
    end
  end

  // read mux; flags are live state, reserved bits read zero
  always_comb begin
    prdata = 32'h0;
    case (paddr)
      `SSX_OFS_TX_STAT:  prdata[7:0] = {tx_stat[7:2], tx_left == 4'h0, tx_stat[0]};
      `SSX_OFS_RX_STAT:  prdata[7:0] = {rx_ctl[7:4], 2'b00, overrun_error, fifo[rd_ptr].bit9};
      `SSX_OFS_BAUD_CTL: prdata[7:0] = baud_ctl;
      `SSX_OFS_DIV_LO:   prdata[7:0] = div_lo;
      `SSX_OFS_DIV_HI:   prdata[7:0] = div_hi;
      `SSX_OFS_RX_DATA:  prdata[7:0] = fifo[rd_ptr].data;
      `SSX_OFS_INT_CTL:  prdata[7:0] = {int_ctl[7:4], 2'b00, receive_flag, transmit_flag};
      default:           prdata = 32'h0;
    endcase
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_d  <= 1'b0;
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
    end else begin
      ck_s1 <= ck_pin_in;
      ck_s2 <= ck_s1;
      ck_d  <= ck_s2;
      dt_s1 <= dt_pin_in;
      dt_s2 <= dt_s1;
    end
  end

  // leading/trailing edge by polarity; only pin edges step the shifters
  logic rise, fall, lead, trail;
  assign rise  = ck_s2 & ~ck_d;                                 // [RULE10]
  assign fall  = ~ck_s2 & ck_d;
  assign lead  = clock_polarity_select ? fall : rise;                            // [RULE23]
  assign trail = clock_polarity_select ? rise : fall;                            // [RULE21]

  // transmit: holding register feeds shifter when it runs empty
  logic tsr_load;
  assign tsr_load = (mode == SSX_TX) & thr_full & (tx_left == 4'h0);
  assign transmit_flag = ~thr_full;                                      // [RULE4] [RULE5]
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      thr      <= 8'h00;
      thr_full <= 1'b0;
    end else if (!serial_port_enable) begin
      thr_full <= 1'b0;                                         // [RULE3]
    end else begin
      if (tsr_load)
        thr_full <= 1'b0;                                       // [RULE5]
      if (wr_thr) begin
        thr      <= pwdata[7:0];
        thr_full <= 1'b1;                                       // [RULE14]
      end
    end
  end

  // transmit shifter; bit goes out on leading edge, counts on trailing
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      transmit_shift_register        <= 9'h000;
      tx_left    <= 4'h0;
      tx_pend    <= 1'b0;
      tx_bit_out <= 1'b0;
    end else if (mode != SSX_TX) begin
      tx_left <= 4'h0;                                          // [RULE3] [RULE9]
      tx_pend <= 1'b0;
    end else if (tsr_load) begin
      transmit_shift_register     <= {tx_stat[`SSX_B_NINTH_BIT_TRANSMIT_VALUE], thr};                   // [RULE4]
      tx_left <= tx9 ? `SSX_BITS_9 : `SSX_BITS_8;
    end else if (tx_left != 4'h0) begin
      if (lead && !tx_pend) begin
        tx_bit_out <= transmit_shift_register[0];                                   // [RULE21] [RULE10]
        transmit_shift_register        <= {1'b0, transmit_shift_register[8:1]};
        tx_pend    <= 1'b1;
      end else if (trail && tx_pend) begin
        tx_left <= tx_left - 4'h1;
        tx_pend <= 1'b0;
      end
    end
  end

  // clock pin is input in every mode, never driven; data driven while transmitting
  assign pins_out.ck_out = clock_polarity_select;
  assign pins_out.ck_oe  = 1'b0;
  assign pins_out.dt_out = tx_bit_out;
  assign pins_out.dt_oe  = (mode == SSX_TX);

  // receive shifter; samples on trailing edge, refuses while overrun
  logic       rx_run, rx_done;
  logic [8:0] next_rsr;
  ssx_char_s  rx_char;
  assign rx_run   = (mode == SSX_RX) & ~overrun_error;                   // [RULE22]
  assign next_rsr = {dt_s2, receive_shift_register[8:1]};
  assign rx_done  = rx_run & trail &
                    (rx_cnt == (rx9 ? `SSX_BITS_9 : `SSX_BITS_8) - 4'h1);
  assign rx_char  = rx9 ? next_rsr : {1'b0, next_rsr[8:1]};
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      receive_shift_register    <= 9'h000;
      rx_cnt <= 4'h0;
    end else if (!rx_run) begin
      rx_cnt <= 4'h0;                                           // [RULE3] [RULE9]
    end else if (trail) begin
      receive_shift_register    <= next_rsr;                                       // [RULE8] [RULE10]
      rx_cnt <= rx_done ? 4'h0 : rx_cnt + 4'h1;
    end
  end

  // two-character receive fifo, flop storage indexed by pointer
  logic push, full;
  assign full = (count == (PW + 1)'(FIFO_DEPTH));
  assign push = rx_done & (~full | pop);
  assign receive_flag = (count != '0);                                  // [RULE12] [RULE16]
  for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_fifo
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
        fifo[i] <= '0;
      else if (push && wr_ptr == PW'(i))
        fifo[i] <= rx_char;                                     // [RULE8]
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (!serial_port_enable) begin
      wr_ptr <= '0;                                             // [RULE3]
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      count <= count + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  // overrun: third whole character with fifo full; cleared by enables
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      overrun_error <= 1'b0;
    else if (!serial_port_enable || !continuous_receive_enable)
      overrun_error <= 1'b0;                                             // [RULE18]
    else if (rx_done && full && !pop)
      overrun_error <= 1'b1;                                             // [RULE22]
  end

  // wake and interrupt; vector call only when global enable also set
  logic tx_ev, rx_ev;
  assign tx_ev = transmit_flag & transmit_int_enable & peripheral_int_enable & (mode == SSX_TX);         // [RULE5]
  assign rx_ev = receive_flag & receive_int_enable;                                   // [RULE8] [RULE16]
  assign wake_req    = core_sleep & (tx_ev | rx_ev);            // [RULE6]
  assign int_req     = global_int_enable & (tx_ev | (rx_ev & peripheral_int_enable));
  assign vector_call = wake_req & global_int_enable;                          // [RULE6]
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      vector_addr <= `SSX_INT_VECTOR;
    else
      vector_addr <= `SSX_INT_VECTOR;
  end

  // checks
  sequence s_tx_loaded;
    tsr_load && thr_full;
  endsequence
  sequence s_third_char;
    rx_done && full && !pop && serial_port_enable && continuous_receive_enable;
  endsequence
  property p_serial_port_enable_reset;
    @(posedge clk_sys) disable iff (!resetn)
      !serial_port_enable |=> (count == '0) && !thr_full && (tx_left == 4'h0) && !overrun_error;
  endproperty
  a_serial_port_enable_reset: assert property (p_serial_port_enable_reset) // [RULE3]
    else $error("port disable did not reset");
  property p_load_sets_flag;
    @(posedge clk_sys) disable iff (!resetn)
      s_tx_loaded and !wr_thr |=> transmit_flag && (tx_left != 4'h0);
  endproperty
  a_load_sets_flag: assert property (p_load_sets_flag) // [RULE5]
    else $error("load kept flag clear");
  property p_write_clears;
    @(posedge clk_sys) disable iff (!resetn)
      wr_thr |=> !transmit_flag;
  endproperty
  a_write_clears: assert property (p_write_clears) // [RULE14]
    else $error("holding write left flag");
  property p_overrun;
    @(posedge clk_sys) disable iff (!resetn)
      s_third_char |=> overrun_error && (count == $past(count)) ##1 !rx_done;
  endproperty
  a_overrun: assert property (p_overrun) else $error("third character not refused"); // [RULE22]
  property p_rx_flag;
    @(posedge clk_sys) disable iff (!resetn)
      rx_done && (count == '0) && serial_port_enable |=> receive_flag && (fifo[rd_ptr] == $past(rx_char));
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("received char not flagged"); // [RULE16]
  property p_sleep_wake;
    @(posedge clk_sys) disable iff (!resetn)
      core_sleep && rx_done && receive_int_enable && (count == '0) && serial_port_enable ##1 core_sleep |-> wake_req;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("no wake on sleep receive"); // [RULE8]
  // data drive is judged in the same cycle: a write may make the unit a slave one cycle later
  property p_master_still;
    @(posedge clk_sys) disable iff (!resetn)
      !slave |-> !pins_out.dt_oe ##1 (tx_left == 4'h0) && (rx_cnt == 4'h0);
  endproperty
  a_master_still: assert property (p_master_still) // [RULE9]
    else $error("shifter ran outside slave");
  property p_no_edge_no_shift;
    @(posedge clk_sys) disable iff (!resetn)
      (mode == SSX_TX) && !lead && !tsr_load |=> $stable(transmit_shift_register);
  endproperty
  a_no_edge_no_shift: assert property (p_no_edge_no_shift) // [RULE10]
    else $error("shift without pin edge");
  property p_single_ignored;
    @(posedge clk_sys) disable iff (!resetn)
      serial_port_enable && slave && single_receive_enable && !continuous_receive_enable |-> (mode != SSX_RX) && !pins_out.dt_oe;
  endproperty
  a_single_ignored: assert property (p_single_ignored) // [RULE7]
    else $error("single enable acted");
endmodule

// *** tb/ssx_ext_master.sv ***
/*
 Behavioural model of the external synchronous master that clocks the slave.
 Assumes the bench resolves the data wire and calls xfer; one bit per 48 ns.
*/
module ssx_ext_master (
  input  wire logic dt_wire, // resolved data line
  output logic      ck,      // shift clock to the slave
  output logic      dt_drv   // data the master puts on the line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pol;
  // clock stands still at its idle level between frames
  initial begin
    pol = 1'b0;
    ck = 1'b0;
    dt_drv = 1'b1;
  end
  // idle level follows the polarity choice
  task automatic set_pol(input logic p);
    #1;
    pol = p;
    ck = p;
  endtask
  // change on leading edge, sample on trailing edge, only n clocks
  task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h000;
    // step off the system clock edge so pin changes never race the synchronisers
    #1;
    for (int i = 0; i < n; i++) begin
      ck = ~pol;
      dt_drv = tx[i];
      #24;
      ck = pol;
      rx[i] = dt_wire;
      #24;
    end
    // released line shows the inverse so a stale level never passes
    dt_drv = ~dt_drv;
  endtask
endmodule

// *** tb/sync_serial_slave_and_sleep_tb.sv ***
/*
 Self-checking bench for the synchronous serial slave: apb master, external
 master model, sleep and wake. Assumes zero-wait apb and 2-flop pin sync.
*/
`include "ssx_defines.svh"
module sync_serial_slave_and_sleep_tb import ssx_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_TX = `SSX_OFS_TX_STAT;
  localparam logic [7:0] A_RX = `SSX_OFS_RX_STAT;
  localparam logic [7:0] A_INT = `SSX_OFS_INT_CTL;
  localparam logic [7:0] A_DAT = `SSX_OFS_RX_DATA;
  localparam logic [7:0] A_HLD = `SSX_OFS_TX_HOLD;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        core_sleep = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wake_req;
  logic        int_req;
  logic        vector_call;
  logic [15:0] vector_addr;
  ssx_pins_s   pins_out;
  logic        m_ck;
  logic        m_dt;
  logic        dt_wire;
  logic        ck_wire;
  logic [31:0] rd;
  logic        err;
  logic [8:0]  rx;
  int          mismatches = 0;
  int          num_checks = 0;
  int          wakes = 0;
  int          vcalls = 0;
  // wire levels resolved from the slave's output enables
  assign dt_wire = pins_out.dt_oe ? pins_out.dt_out : m_dt;
  assign ck_wire = pins_out.ck_oe ? pins_out.ck_out : m_ck;
  always #2 clk_sys = ~clk_sys;
  ssx_serial ssx_serial_i (
    .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ck_pin_in(ck_wire), .dt_pin_in(dt_wire),
    .pins_out(pins_out), .core_sleep(core_sleep), .wake_req(wake_req),
    .int_req(int_req), .vector_call(vector_call), .vector_addr(vector_addr)
  );
  ssx_ext_master ssx_ext_master_i (.dt_wire(dt_wire), .ck(m_ck), .dt_drv(m_dt));
  // wake and vector calls are counted so a short pulse is not missed
  always @(posedge clk_sys) begin
    if (wake_req === 1'b1) wakes <= wakes + 1;
    if (vector_call === 1'b1 && vector_addr === 16'h0004) vcalls <= vcalls + 1;
  end
  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(a, 1'b0, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  // frame plus sync and detect latency of the pin edges
  task automatic send(input logic [8:0] d, input int n);
    ssx_ext_master_i.xfer(d, n, rx);
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic t_regs();
    rdc(A_INT, 8'h01);
    rdc(A_RX, 8'h00);
    wr(`SSX_OFS_DIV_LO, 8'ha5);
    rdc(`SSX_OFS_DIV_LO, 8'ha5);
    apb(8'h20, 1'b0, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask
  task automatic t_rx();
    wr(A_TX, 8'h10);
    wr(A_INT, 8'he0);
    wr(A_RX, 8'hb0);
    chk({31'h0, pins_out.ck_oe}, 32'h0);
    send(9'h03c, 8);
    chk({31'h0, int_req}, 32'h1);
    rdc(A_INT, 8'he3);
    rdc(A_DAT, 8'h3c);
    wr(A_RX, 8'hf0);
    send(9'h1a5, 9);
    rdc(A_RX, 8'hf1);
    rdc(A_DAT, 8'ha5);
  endtask
  // third character is refused and the stored two survive
  task automatic t_ovr();
    wr(A_RX, 8'hb0);
    send(9'h011, 8);
    send(9'h022, 8);
    send(9'h033, 8);
    rdc(A_RX, 8'hb2);
    rdc(A_DAT, 8'h11);
    rdc(A_DAT, 8'h22);
    wr(A_RX, 8'ha0);
    rdc(A_RX, 8'ha0);
    wr(A_RX, 8'hb0);
    send(9'h044, 8);
    wr(A_RX, 8'h00);
    rdc(A_INT, 8'he1);
  endtask
  task automatic t_sleep_rx();
    int w0;
    int v0;
    wr(A_RX, 8'hb0);
    w0 = wakes;
    v0 = vcalls;
    core_sleep <= 1'b1;
    send(9'h05a, 8);
    chk(32'(wakes != w0), 32'h1);
    chk(32'(vcalls != v0), 32'h1);
    rdc(A_DAT, 8'h5a);
    wr(A_RX, 8'h80);
    wr(A_TX, 8'h90);
    wr(A_RX, 8'h90);
    send(9'h077, 8);
    rdc(A_INT, 8'he1);
    core_sleep <= 1'b0;
  endtask
  // polarity flipped here so both idle levels get exercised
  task automatic t_sleep_tx();
    int w0;
    wr(A_RX, 8'h00);
    wr(`SSX_OFS_BAUD_CTL, 8'h10);
    ssx_ext_master_i.set_pol(1'b1);
    chk({31'h0, pins_out.ck_out}, 32'h1);
    wr(A_TX, 8'h30);
    wr(A_RX, 8'h80);
    wr(A_INT, 8'h50);
    wr(A_HLD, 8'hc3);
    wr(A_HLD, 8'h96);
    w0 = wakes;
    core_sleep <= 1'b1;
    rdc(A_INT, 8'h50);
    ssx_ext_master_i.xfer(9'h000, 8, rx);
    chk({23'h0, rx}, 32'h0c3);
    repeat (6) @(posedge clk_sys);
    chk(32'(wakes != w0), 32'h1);
    rdc(A_INT, 8'h51);
    wr(A_HLD, 8'h3f);
    rdc(A_INT, 8'h50);
    ssx_ext_master_i.xfer(9'h000, 8, rx);
    chk({23'h0, rx}, 32'h096);
    core_sleep <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_rx();
    t_ovr();
    t_sleep_rx();
    t_sleep_tx();
    finish_test();
  end
  // watchdog well beyond the expected run of about 4.6 us
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end
endmodule
